// ==== src/pbs_sequencer.sv ====
`timescale 1ns/10ps
// How it works
// - lines run in table order except where an event branch jumps, each naming one block or one subsequence call.
// - a line repeats its block from 1 to 65536 times, or without bound.
// - a per-line selector picks counted repeats or infinite repeats left only by other means.
// - with trigger hold on, output halts on reaching the line until the trigger input comes.
// - with event branch on, a pending event during the line sends control to its target line.
// - each line holds a target line used only by its event branch.
// - hold, branch and target act only in enhanced run mode and are ignored otherwise.
// - only the first 2048 expanded steps run; later steps are dropped without any error.
// - a subsequence holds only blocks with their own repeat counts and is called from a main line.
// - every rising edge of the event input latches a pending flag, tested at each emitted block and cleared only when a branch is taken.
// - an event branch is taken even before the line has used up its repeat count.
// - each branch drives an 8-clock event output pulse starting 22 clocks before the block switch.
// - a call takes subsequence lines times its repeat count in steps; any other line takes one.
module pbs_sequencer
  import pbs_pkg::*;
#(
  parameter int NLINES   = 16,
  parameter int NSUBS    = 4,
  parameter int SUBLINES = 8,
  parameter int STEP_MAX = STEP_LIMIT
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              trig_in,
  input  wire logic              event_in,
  output logic                   event_out,
  output logic                   pat_valid,
  input  wire logic              pat_ready,
  output pbs_word_t              pat_data
);
  localparam int LA  = $clog2(NLINES);
  localparam int SA  = $clog2(NSUBS);
  localparam int SLA = $clog2(SUBLINES);

  if (NLINES < 2 || NLINES > 255 || NSUBS < 2 || NSUBS > DOC_SUBS || SUBLINES < 2 ||
      SUBLINES > DOC_SUB_LINES || STEP_MAX < 1 || STEP_MAX > (1 << STEP_W)) begin : g_chk
    $error("sequencer parameters out of range");
  end

  function automatic logic step_ok(input logic [STEP_W:0] base, input logic [STEP_W:0] off);
    step_ok = ({1'b0, base} + {1'b0, off}) < (STEP_W+2)'(STEP_MAX);
  endfunction

  // ****************************************************************
  // tables
  // ****************************************************************
  pbs_line_t         lines_r  [NLINES];
  logic [LA-1:0]     tgt_r    [NLINES];
  pbs_sub_t          subs_r   [NSUBS][SUBLINES];
  logic [SLA:0]      sublen_r [NSUBS];
  logic [STEP_W:0]   base_r   [NLINES];
  logic              ok_r     [NLINES];

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic              pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0]       prdata_r, prdata_nxt;
  logic              enh_r, enh_nxt;
  logic [LA:0]       nlines_r, nlines_nxt;
  logic [7:0]        laddr_r, laddr_nxt;
  logic [15:0]       saddr_r, saddr_nxt;
  logic              acc, wr, hit, start_req, stop_req;
  logic              we_line, we_tgt, we_sub, we_len;
  logic [LA-1:0]     wl;
  logic [SA-1:0]     ws;
  logic [SLA-1:0]    wsl;
  pbs_state_t        st_r, st_nxt;
  logic [LA:0]       line_r, line_nxt;
  logic              ev_pend_r;

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  always_comb begin
    acc         = psel && penable;
    wr          = acc && pready_r && pwrite;
    wl          = laddr_r[LA-1:0];
    ws          = saddr_r[SA_SUB_LSB +: SA];
    wsl         = saddr_r[SLA-1:0];
    hit         = 1'b1;
    prdata_nxt  = 32'h0000_0000;
    case (paddr)
      REG_CTRL:      prdata_nxt[CTRL_ENH_BIT] = enh_r;
      REG_STATUS: begin
        prdata_nxt[ST_BUSY_BIT] = (st_r != PBS_IDLE);
        prdata_nxt[ST_HOLD_BIT] = (st_r == PBS_HOLD);
        prdata_nxt[ST_EVP_BIT]  = ev_pend_r;
        prdata_nxt[ST_LINE_LSB +: LA+1] = line_r;
      end
      REG_NLINES:    prdata_nxt[LA:0] = nlines_r;
      REG_LINE_ADDR: prdata_nxt[7:0] = laddr_r;
      REG_LINE_DATA: prdata_nxt[LD_BR_BIT:0] = lines_r[wl];
      REG_LINE_TGT:  prdata_nxt[LA-1:0] = tgt_r[wl];
      REG_SUB_ADDR:  prdata_nxt[15:0] = saddr_r;
      REG_SUB_DATA:  prdata_nxt[LD_SUB_BIT-1:0] = subs_r[ws][wsl];
      REG_SUB_LEN:   prdata_nxt[SLA:0] = sublen_r[ws];
      default:       hit = 1'b0;
    endcase
    pready_nxt  = acc && !pready_r;
    pslverr_nxt = acc && !pready_r && !hit;
    if (!pready_nxt) begin
      prdata_nxt = prdata_r;
    end
    enh_nxt     = (wr && paddr == REG_CTRL) ? pwdata[CTRL_ENH_BIT] : enh_r;
    start_req   = wr && paddr == REG_CTRL && pwdata[CTRL_START_BIT];
    stop_req    = wr && paddr == REG_CTRL && pwdata[CTRL_STOP_BIT];
    nlines_nxt  = (wr && paddr == REG_NLINES) ? pwdata[LA:0] : nlines_r;
    laddr_nxt   = (wr && paddr == REG_LINE_ADDR) ? pwdata[7:0] : laddr_r;
    saddr_nxt   = (wr && paddr == REG_SUB_ADDR) ? pwdata[15:0] : saddr_r;
    we_line     = wr && paddr == REG_LINE_DATA && laddr_r < 8'(NLINES);
    we_tgt      = wr && paddr == REG_LINE_TGT && laddr_r < 8'(NLINES);
    we_sub      = wr && paddr == REG_SUB_DATA && saddr_r[15:SA_SUB_LSB] < 8'(NSUBS)
                  && saddr_r[7:0] < 8'(SUBLINES);
    we_len      = wr && paddr == REG_SUB_LEN && saddr_r[15:SA_SUB_LSB] < 8'(NSUBS);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      enh_r     <= ENH_RST;
      nlines_r  <= '0;
      laddr_r   <= ADDR_RST;
      saddr_r   <= {ADDR_RST, ADDR_RST};
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
      enh_r     <= enh_nxt;
      nlines_r  <= nlines_nxt;
      laddr_r   <= laddr_nxt;
      saddr_r   <= saddr_nxt;
    end
  end

  always_ff @(posedge pclk) begin
    if (we_line) begin
      lines_r[wl] <= pbs_line_t'(pwdata[LD_BR_BIT:LD_REP_LSB]);
    end
    if (we_tgt) begin
      tgt_r[wl] <= pwdata[LA-1:0];
    end
    if (we_sub) begin
      subs_r[ws][wsl] <= pbs_sub_t'(pwdata[LD_SUB_BIT-1:LD_REP_LSB]);
    end
    if (we_len) begin
      sublen_r[ws] <= (pwdata[15:0] > 16'(SUBLINES)) ? (SLA+1)'(SUBLINES) : pwdata[SLA:0];
    end
  end

  // ****************************************************************
  // step expansion, one line per cycle at start
  // ****************************************************************
  logic [LA:0]       cidx_r, cidx_nxt;
  logic [STEP_W:0]   cacc_r, cacc_nxt;
  logic [31:0]       csize;
  pbs_line_t         cl;

  always_comb begin
    cl       = lines_r[cidx_r[LA-1:0]];
    csize    = cl.is_sub ? 32'(sublen_r[cl.id[SA-1:0]]) * (32'(cl.rep_m1) + 32'h1) : 32'h1;
    cidx_nxt = (st_r == PBS_COMPILE) ? cidx_r + 1'b1 : '0;
    cacc_nxt = '0;
    if (st_r == PBS_COMPILE) begin
      cacc_nxt = (32'(cacc_r) + csize >= 32'(STEP_MAX)) ? (STEP_W+1)'(STEP_MAX)
                                                      : (STEP_W+1)'(32'(cacc_r) + csize);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cidx_r <= '0;
      cacc_r <= '0;
    end else begin
      cidx_r <= cidx_nxt;
      cacc_r <= cacc_nxt;
    end
  end

  always_ff @(posedge pclk) begin
    if (st_r == PBS_COMPILE && cidx_r < (LA+1)'(NLINES)) begin
      base_r[cidx_r[LA-1:0]] <= cacc_r;
      ok_r[cidx_r[LA-1:0]]   <= step_ok(cacc_r, '0);
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  logic [REP_W-1:0]  rep_r, rep_nxt, iter_r, iter_nxt, srep_r, srep_nxt;
  logic [SLA-1:0]    sline_r, sline_nxt;
  logic [STEP_W:0]   off_r, off_nxt;
  logic [EV_CNT_W-1:0] evc_r, evc_nxt;
  logic              ev_prev_r, ev_pend_nxt, evo_r, evo_nxt;
  logic              push, fifo_rdy, branch_now, ev_clr;
  pbs_line_t         cur;
  pbs_sub_t          sub;
  logic [SLA:0]      slen;
  pbs_word_t         word;

  always_comb begin
    cur        = lines_r[line_r[LA-1:0]];
    sub        = subs_r[cur.id[SA-1:0]][sline_r];
    slen       = sublen_r[cur.id[SA-1:0]];
    word.line  = LINE_FIELD_W'(line_r);
    word.block = cur.is_sub ? sub.block : cur.id;
    push       = (st_r == PBS_EMIT);
    branch_now = enh_r && cur.ev_branch && ev_pend_r;
    ev_clr     = 1'b0;
    st_nxt     = st_r;
    line_nxt   = line_r;
    rep_nxt    = rep_r;
    iter_nxt   = iter_r;
    srep_nxt   = srep_r;
    sline_nxt  = sline_r;
    off_nxt    = off_r;
    evc_nxt    = evc_r;
    case (st_r)
      PBS_IDLE: begin
        line_nxt = '0;
        if (start_req) begin
          st_nxt = PBS_COMPILE;
        end
      end
      PBS_COMPILE: begin
        if (cidx_r == (LA+1)'(NLINES) - 1'b1) begin
          st_nxt = PBS_FETCH;
        end
      end
      PBS_FETCH: begin
        rep_nxt   = '0;
        iter_nxt  = '0;
        srep_nxt  = '0;
        sline_nxt = '0;
        off_nxt   = '0;
        if (line_r >= nlines_r || line_r >= (LA+1)'(NLINES) || !ok_r[line_r[LA-1:0]]) begin
          st_nxt = PBS_IDLE;
        end else if (cur.is_sub && slen == '0) begin
          line_nxt = line_r + 1'b1;
        end else if (enh_r && cur.trig_hold) begin
          st_nxt = PBS_HOLD;
        end else begin
          st_nxt = PBS_EMIT;
        end
      end
      PBS_HOLD: begin
        if (trig_in) begin
          st_nxt = PBS_EMIT;
        end
      end
      PBS_EMIT: begin
        if (fifo_rdy) begin
          if (branch_now) begin
            ev_clr   = 1'b1;
            evc_nxt  = EV_CNT_W'(EV_LEAD_CLKS);
            line_nxt = {1'b0, tgt_r[line_r[LA-1:0]]};
            st_nxt   = PBS_BRANCH;
          end else if (!cur.is_sub) begin
            if (!cur.infinite && rep_r == cur.rep_m1) begin
              line_nxt = line_r + 1'b1;
              st_nxt   = PBS_FETCH;
            end else begin
              rep_nxt = rep_r + 1'b1;
            end
          end else if (srep_r != sub.rep_m1) begin
            srep_nxt = srep_r + 1'b1;
          end else begin
            srep_nxt = '0;
            off_nxt  = off_r + 1'b1;
            if (!step_ok(base_r[line_r[LA-1:0]], off_r + 1'b1)) begin
              st_nxt = PBS_IDLE;
            end else if ((SLA+1)'(sline_r) == slen - 1'b1) begin
              sline_nxt = '0;
              if (!cur.infinite && iter_r == cur.rep_m1) begin
                line_nxt = line_r + 1'b1;
                st_nxt   = PBS_FETCH;
              end else begin
                iter_nxt = iter_r + 1'b1;
              end
            end else begin
              sline_nxt = sline_r + 1'b1;
            end
          end
        end
      end
      PBS_BRANCH: begin
        evc_nxt = evc_r - 1'b1;
        if (evc_r == EV_CNT_W'(BR_FETCH_AT)) begin
          st_nxt = PBS_FETCH;
        end
      end
      default: st_nxt = PBS_IDLE;
    endcase
    if (stop_req) begin
      st_nxt = PBS_IDLE;
    end
    ev_pend_nxt = (event_in && !ev_prev_r) ? 1'b1 : (ev_clr ? 1'b0 : ev_pend_r);
    evo_nxt     = (st_nxt == PBS_BRANCH) && (evc_nxt > EV_CNT_W'(EV_LEAD_CLKS - EV_PULSE_CLKS));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= PBS_IDLE;
      line_r    <= '0;
      rep_r     <= '0;
      iter_r    <= '0;
      srep_r    <= '0;
      sline_r   <= '0;
      off_r     <= '0;
      evc_r     <= '0;
      ev_prev_r <= 1'b0;
      ev_pend_r <= 1'b0;
      evo_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      line_r    <= line_nxt;
      rep_r     <= rep_nxt;
      iter_r    <= iter_nxt;
      srep_r    <= srep_nxt;
      sline_r   <= sline_nxt;
      off_r     <= off_nxt;
      evc_r     <= evc_nxt;
      ev_prev_r <= event_in;
      ev_pend_r <= ev_pend_nxt;
      evo_r     <= evo_nxt;
    end
  end

  assign event_out = evo_r;

  // ****************************************************************
  // pattern output buffer
  // ****************************************************************
  pbs_fifo #(
    .W     ($bits(pbs_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .in_data   (word),
    .out_valid (pat_valid),
    .out_ready (pat_ready),
    .out_data  (pat_data)
  );

endmodule

// ==== include/pbs_pkg.sv ====
package pbs_pkg;

  // ****************************************************************
  // table formats
  // ****************************************************************
  localparam int REP_W          = 16;     // repeat stored minus one: 1..65536
  localparam int ID_W           = 8;
  localparam int LINE_FIELD_W   = 8;
  localparam int STEP_LIMIT     = 2048;   // expanded steps that run
  localparam int STEP_W         = 12;
  localparam int DOC_SUB_LINES  = 256;
  localparam int DOC_SUBS       = 50;

  // ****************************************************************
  // event branch timing, in pclk cycles
  // ****************************************************************
  localparam int EV_LEAD_CLKS   = 22;
  localparam int EV_PULSE_CLKS  = 8;
  localparam int EV_CNT_W       = 5;
  localparam int BR_FETCH_AT    = 3;      // leaves fetch and emit cycles

  localparam int FIFO_DEPTH     = 32;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_NLINES    = 8'h08;
  localparam logic [7:0] REG_LINE_ADDR = 8'h0c;
  localparam logic [7:0] REG_LINE_DATA = 8'h10;
  localparam logic [7:0] REG_LINE_TGT  = 8'h14;
  localparam logic [7:0] REG_SUB_ADDR  = 8'h18;
  localparam logic [7:0] REG_SUB_DATA  = 8'h1c;
  localparam logic [7:0] REG_SUB_LEN   = 8'h20;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ENH_BIT   = 1;
  localparam int CTRL_STOP_BIT  = 2;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_HOLD_BIT    = 1;
  localparam int ST_EVP_BIT     = 2;
  localparam int ST_LINE_LSB    = 8;
  localparam int LD_REP_LSB     = 0;      // line word: [15:0] repeat-1
  localparam int LD_ID_LSB      = 16;     // [23:16] block or subsequence
  localparam int LD_SUB_BIT     = 24;
  localparam int LD_INF_BIT     = 25;
  localparam int LD_HOLD_BIT    = 26;
  localparam int LD_BR_BIT      = 27;
  localparam int SA_SUB_LSB     = 8;      // sub address: [15:8] sub, [7:0] line
  localparam logic       ENH_RST    = 1'b0;
  localparam logic [7:0] ADDR_RST   = 8'h00;

  typedef struct packed {
    logic              ev_branch;
    logic              trig_hold;
    logic              infinite;
    logic              is_sub;
    logic [ID_W-1:0]   id;
    logic [REP_W-1:0]  rep_m1;
  } pbs_line_t;

  typedef struct packed {
    logic [ID_W-1:0]   block;
    logic [REP_W-1:0]  rep_m1;
  } pbs_sub_t;

  typedef struct packed {
    logic [LINE_FIELD_W-1:0] line;
    logic [ID_W-1:0]         block;
  } pbs_word_t;

  typedef enum {PBS_IDLE, PBS_COMPILE, PBS_FETCH, PBS_HOLD, PBS_EMIT, PBS_BRANCH} pbs_state_t;

endpackage

// ==== src/pbs_fifo.sv ====
`timescale 1ns/10ps
module pbs_fifo
  import pbs_pkg::*;
#(
  parameter int W     = 16,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("depth must be a power of two, at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          ov_r, ov_nxt;
  logic [W-1:0]  od_r, od_nxt;
  logic          push, pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = ov_r;
  assign out_data  = od_r;

  always_comb begin
    push    = in_valid && in_ready;
    pop     = (cnt_r != '0) && (!ov_r || out_ready);
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    ov_nxt  = pop ? 1'b1 : (out_ready ? 1'b0 : ov_r);
    od_nxt  = pop ? mem[rp_r] : od_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      ov_r  <= 1'b0;
      od_r  <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      ov_r  <= ov_nxt;
      od_r  <= od_nxt;
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

endmodule

// ==== sim/pbs_sequencer_sva.sv ====
`timescale 1ns/10ps
// ********
// port checker
// ********
module pbs_seq_sva
  import pbs_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        event_out,
  input wire logic        pat_valid,
  input wire logic        pat_ready,
  input wire pbs_word_t   pat_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_wait: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_pready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
  a_idle_quiet: assert property (!psel |-> !pready) else $error("pready unselected");
  a_err_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
  a_evout_width: assert property ($rose(event_out) |-> event_out [*8] ##1 !event_out)
    else $error("event pulse width");
  a_evout_gap: assert property ($fell(event_out) |-> !event_out [*8]) else $error("event gap");
  a_pat_hold: assert property (pat_valid && !pat_ready |=> pat_valid && $stable(pat_data))
    else $error("word dropped");
  c_branch: cover property ($rose(event_out));
  c_slverr: cover property (pslverr);
  c_stall: cover property (pat_valid && !pat_ready [*4]);
endmodule

bind pbs_sequencer pbs_seq_sva pbs_seq_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_out(event_out),
  .pat_valid(pat_valid), .pat_ready(pat_ready), .pat_data(pat_data));

// ==== sim/pbs_pod_model.sv ====
`timescale 1ns/10ps
// ********
// pod: trigger level and event edges
// ********
module pbs_pod_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trig_req,
  input  wire logic ev_req,
  output logic      trig_in,
  output logic      event_in
);
  logic [1:0] ev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_in <= 1'h0;
      ev_r    <= 2'h0;
    end else begin
      trig_in <= trig_req;
      ev_r    <= ev_req ? 2'h3 : {1'h0, ev_r[1]};
    end
  end
  assign event_in = ev_r[0];
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
// ********
// bench
// ********
module testbench;
  import pbs_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        trig_req = 0, ev_req = 0, pat_ready = 1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, trig_in, event_in, event_out, pat_valid, e;
  pbs_word_t   pat_data, w;
  int          mismatches = 0, n_compared = 0, k;
  always #12.5 pclk = ~pclk;
  pbs_sequencer #(.STEP_MAX(8)) pbs_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .event_in(event_in), .event_out(event_out),
    .pat_valid(pat_valid), .pat_ready(pat_ready), .pat_data(pat_data));
  pbs_pod_model pbs_pod_model_inst (.pclk(pclk), .presetn(presetn), .trig_req(trig_req),
    .ev_req(ev_req), .trig_in(trig_in), .event_in(event_in));
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fail;
    mismatches++;
    results();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic chkp(input pbs_word_t g, input pbs_word_t x);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR t=%0t word %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (!pready && i < 50);
    if (!pready) fail();
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic setline(input logic [31:0] n, input logic [31:0] d);
    wr(REG_LINE_ADDR, n);
    wr(REG_LINE_DATA, d);
    wr(REG_LINE_TGT, 32'h0);
  endtask
  task automatic rcv(output pbs_word_t r);
    int i;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (!(pat_valid && pat_ready) && i < 500);
    if (!(pat_valid && pat_ready)) fail();
    r = pat_data;
  endtask
  task automatic get(input logic [7:0] l, input logic [7:0] b, input int n);
    pbs_word_t r;
    repeat (n) begin
      rcv(r);
      chkp(r, {l, b});
    end
  endtask
  task automatic sub(input int n);
    repeat (n) begin
      get(8'h01, 8'h21, 1);
      get(8'h01, 8'h22, 2);
    end
  endtask
  task automatic pulse(input logic t);
    if (t) trig_req <= 1'h1;
    else ev_req <= 1'h1;
    @(posedge pclk);
    trig_req <= 1'h0;
    ev_req <= 1'h0;
  endtask
  task automatic idle_chk;
    repeat (8) @(posedge pclk);
    rd(REG_STATUS);
    chk(q & 32'h1, 32'h0);
    chk({31'h0, pat_valid}, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(REG_STATUS);
    chk(q, 32'h0);
    rd(REG_NLINES);
    chk(q, 32'h0);
    rd(8'hfc);
    chk({31'h0, e}, 32'h1);
    wr(REG_NLINES, 32'h3);
    rd(REG_NLINES);
    chk(q, 32'h3);
    setline(32'h0, 32'h0011_0002);
    setline(32'h1, 32'h0100_0001);
    setline(32'h2, 32'h0433_0000);
    setline(32'h3, 32'h0a44_0000);
    wr(REG_SUB_ADDR, 32'h0);
    wr(REG_SUB_DATA, 32'h0021_0000);
    wr(REG_SUB_ADDR, 32'h1);
    wr(REG_SUB_DATA, 32'h0022_0001);
    wr(REG_SUB_LEN, 32'h2);
    wr(REG_CTRL, 32'h1);
    get(8'h00, 8'h11, 3);
    sub(2);
    get(8'h02, 8'h33, 1);
    idle_chk();
    setline(32'h1, 32'h0100_0003);
    wr(REG_CTRL, 32'h1);
    get(8'h00, 8'h11, 3);
    sub(3);
    get(8'h01, 8'h21, 1);
    idle_chk();
    setline(32'h1, 32'h0100_0001);
    wr(REG_NLINES, 32'h4);
    wr(REG_CTRL, 32'h3);
    get(8'h00, 8'h11, 3);
    sub(2);
    repeat (4) @(posedge pclk);
    rd(REG_STATUS);
    chk(q, 32'h0000_0203);
    pulse(1'h0);
    repeat (4) @(posedge pclk);
    rd(REG_STATUS);
    chk(q, 32'h0000_0207);
    pulse(1'h1);
    get(8'h02, 8'h33, 1);
    get(8'h03, 8'h44, 1);
    get(8'h00, 8'h11, 3);
    sub(2);
    repeat (4) @(posedge pclk);
    rd(REG_STATUS);
    chk(q, 32'h0000_0203);
    pulse(1'h1);
    get(8'h02, 8'h33, 1);
    pat_ready <= 1'h0;
    repeat (80) @(posedge pclk);
    chk({31'h0, pat_valid}, 32'h1);
    pat_ready <= 1'h1;
    get(8'h03, 8'h44, 40);
    pulse(1'h0);
    k = 0;
    while (!event_out && k < 50) begin
      @(posedge pclk);
      k++;
    end
    k = 0;
    while (event_out && k < 50) begin
      @(posedge pclk);
      k++;
    end
    chk(k, 32'h8);
    k = 0;
    do begin
      rcv(w);
      k++;
    end while (w.block === 8'h44 && k < 200);
    chkp(w, {8'h00, 8'h11});
    wr(REG_CTRL, 32'h4);
    rd(REG_STATUS);
    chk(q & 32'h1, 32'h0);
    results();
  end
endmodule
